//--- hw/twb_engine.sv
`timescale 1ns/10ps
module twb_engine (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_link,
   input wire logic enable,
   input wire logic peripheral_event_mute,
   input wire logic cmd_valid,
   input wire twb_pkg::twb_cmd_t cmd,
   output logic cmd_ready,
   output twb_pkg::twb_stat_t status,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   import twb_pkg::*;

   logic [1:0] lrst_q;
   logic rst_link_n;
   twb_cmd_t cmd_hold_q;
   logic req_tgl_q, cmd_ready_q, ack_seen_q;
   logic [1:0] ack_sync_q, stat_sync_q;
   logic stat_seen_q;
   twb_stat_t status_q;
   logic [4:0] ls1_q, ls2_q;
   logic req_prev_q, ack_tgl_q, scl_p_q, sda_p_q;
   logic [1:0] sack_sync_q;
   logic stat_tgl_q;
   twb_stat_t stat_hold_q, stat_now;
   twb_state_t state_q;
   logic [7:0] shreg_q, tim_q;
   logic [3:0] bit_cnt_q;
   logic [1:0] phase_q;
   logic master_q, tx_q, sta_q, sto_q, ack_req_q, arb_q, ack_q, event_q, busy_q;
   logic written_q, mute_nack_q, first_q, rx_hold_q, nack_addr_q, hi_q;
   logic scl_oe_q, sda_oe_q, scl_o_q, sda_o_q;
   logic eng_rst, scl_s, sda_s, en_s, mute_s, scl_rise, scl_fall, start_det, stop_det;
   logic cmd_app, go, tim_zero, ack_eff;

   // Link domain reset, synchronised from the system reset
   always_ff @(posedge clk_link) begin
      lrst_q <= {lrst_q[0], rst_n};
   end
   assign rst_link_n = lrst_q[1];

   // System side: hold a command until the link side returns its toggle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cmd_hold_q <= CMD_RESET;
         req_tgl_q <= 1'b0;
         cmd_ready_q <= 1'b1;
      end else if (cmd_valid && cmd_ready_q) begin
         cmd_hold_q <= cmd;
         req_tgl_q <= ~req_tgl_q;
         cmd_ready_q <= 1'b0;
      end else if (ack_sync_q[1] != ack_seen_q) begin
         cmd_ready_q <= 1'b1;
      end
   end

   // System side synchronisers and status capture
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ack_sync_q <= 2'h0;
         ack_seen_q <= 1'b0;
         stat_sync_q <= 2'h0;
         stat_seen_q <= 1'b0;
         status_q <= STAT_RESET;
      end else begin
         ack_sync_q <= {ack_sync_q[0], ack_tgl_q};
         ack_seen_q <= ack_sync_q[1];
         stat_sync_q <= {stat_sync_q[0], stat_tgl_q};
         stat_seen_q <= stat_sync_q[1];
         if (stat_sync_q[1] != stat_seen_q) begin
            status_q <= stat_hold_q; // Held stable by the link side until acknowledged
         end
      end
   end
   assign cmd_ready = cmd_ready_q;
   assign status = status_q;

   // Link side synchronisers for pins, levels and the command toggle
   always_ff @(posedge clk_link) begin
      if (!rst_link_n) begin
         ls1_q <= 5'h03;
         ls2_q <= 5'h03;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         req_prev_q <= 1'b0;
         sack_sync_q <= 2'h0;
      end else begin
         ls1_q <= {req_tgl_q, peripheral_event_mute, enable, sda_i, scl_i};
         ls2_q <= ls1_q;
         scl_p_q <= ls2_q[0];
         sda_p_q <= ls2_q[1];
         req_prev_q <= ls2_q[4];
         sack_sync_q <= {sack_sync_q[0], stat_seen_q};
      end
   end

   // Bus condition decode on synchronised lines only
   always_comb begin
      scl_s = ls2_q[0];
      sda_s = ls2_q[1];
      en_s = ls2_q[2];
      mute_s = ls2_q[3];
      scl_rise = scl_s & ~scl_p_q;
      scl_fall = ~scl_s & scl_p_q;
      start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
      stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
      cmd_app = ls2_q[4] ^ req_prev_q;
      go = cmd_app & cmd_hold_q.clear_event & event_q;
      tim_zero = (tim_q == 8'h00);
      ack_eff = cmd_hold_q.write_ctrl ? cmd_hold_q.ack : ack_q;
      eng_rst = ~rst_link_n | ~en_s;
   end

   // Status word assembled from the engine state
   always_comb begin
      stat_now.vector = {master_q, tx_q, sta_q, sto_q};
      stat_now.ack_req = ack_req_q;
      stat_now.arb_lost = arb_q;
      stat_now.ack = ack_q;
      stat_now.event_flag = event_q;
      stat_now.busy = busy_q;
      stat_now.data = shreg_q;
   end

   // Link side: command acknowledge and status hand-off
   always_ff @(posedge clk_link) begin
      if (!rst_link_n) begin
         ack_tgl_q <= 1'b0;
         stat_tgl_q <= 1'b0;
         stat_hold_q <= STAT_RESET;
      end else begin
         if (cmd_app) begin
            ack_tgl_q <= ~ack_tgl_q;
         end
         if ((stat_tgl_q == sack_sync_q[1]) && (stat_now != stat_hold_q)) begin
            stat_hold_q <= stat_now;
            stat_tgl_q <= ~stat_tgl_q;
         end
      end
   end

   // Byte engine: modes, flags, shifting and line drive
   always_ff @(posedge clk_link) begin
      if (eng_rst) begin
         state_q <= ST_IDLE;
         shreg_q <= 8'h00;
         tim_q <= 8'h00;
         bit_cnt_q <= 4'h0;
         phase_q <= 2'h0;
         {master_q, tx_q, sta_q, sto_q, ack_req_q, arb_q, ack_q, event_q} <= 8'h00;
         {busy_q, written_q, mute_nack_q, first_q, rx_hold_q, nack_addr_q, hi_q} <= 7'h00;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         if (!tim_zero) begin
            tim_q <= tim_q - 8'h01;
         end
         // Software command, applied before hardware sets so a set wins
         if (cmd_app) begin
            if (cmd_hold_q.write_ctrl) begin
               sta_q <= cmd_hold_q.begin_condition_request;
               sto_q <= cmd_hold_q.end_condition_request;
               ack_q <= cmd_hold_q.ack;
            end
            if (cmd_hold_q.write_data && event_q) begin
               shreg_q <= cmd_hold_q.data;
               written_q <= 1'b1;
            end
            if (go) begin
               event_q <= 1'b0;
               arb_q <= 1'b0;
               ack_req_q <= 1'b0;
            end
            if (cmd_hold_q.write_data && event_q && tx_q && !master_q && !ack_q && !rx_hold_q) begin
               arb_q <= 1'b1;
            end
         end
         // Master clock generator, stretch aware
         if (master_q && (state_q == ST_BITS || state_q == ST_ACK)) begin
            if (scl_rise) begin
               tim_q <= HALF_CYC;
               hi_q <= 1'b1;
            end else if (scl_oe_q && tim_zero) begin
               scl_oe_q <= 1'b0;
            end else if (!scl_oe_q && scl_s && hi_q && tim_zero) begin
               scl_oe_q <= 1'b1;
               hi_q <= 1'b0;
               tim_q <= HALF_CYC;
            end
         end
         unique case (state_q)
            ST_IDLE: begin
               scl_oe_q <= 1'b0;
               sda_oe_q <= 1'b0;
               if (sta_q && !busy_q && !event_q && !start_det) begin
                  state_q <= ST_START;
                  master_q <= 1'b1;
                  tx_q <= 1'b1;
                  sda_oe_q <= 1'b1;
                  tim_q <= HALF_CYC;
               end
            end
            ST_START: begin
               if (tim_zero) begin
                  scl_oe_q <= 1'b1;
                  event_q <= 1'b1;
                  state_q <= ST_HOLD;
                  rx_hold_q <= 1'b0;
                  first_q <= 1'b1;
                  written_q <= 1'b0;
               end
            end
            ST_RSTART: begin
               unique case (phase_q)
                  2'h0: if (tim_zero) begin
                     scl_oe_q <= 1'b0;
                     phase_q <= 2'h1;
                  end
                  2'h1: if (scl_s) begin
                     tim_q <= QUARTER_CYC;
                     phase_q <= 2'h2;
                  end
                  default: if (tim_zero) begin
                     if (!sda_s) begin
                        master_q <= 1'b0;
                        tx_q <= 1'b0;
                        arb_q <= 1'b1;
                        event_q <= 1'b1;
                        state_q <= ST_IDLE;
                     end else begin
                        sda_oe_q <= 1'b1;
                        tim_q <= HALF_CYC;
                        state_q <= ST_START;
                     end
                  end
               endcase
            end
            ST_STOP: begin
               unique case (phase_q)
                  2'h0: if (tim_zero) begin
                     scl_oe_q <= 1'b0;
                     phase_q <= 2'h1;
                  end
                  2'h1: if (scl_s) begin
                     tim_q <= QUARTER_CYC;
                     phase_q <= 2'h2;
                  end
                  2'h2: if (tim_zero) begin
                     sda_oe_q <= 1'b0;
                     tim_q <= HALF_CYC;
                     phase_q <= 2'h3;
                  end
                  2'h3: if (tim_zero) begin
                     master_q <= 1'b0;
                     tx_q <= 1'b0;
                     state_q <= ST_IDLE;
                     if (!sda_s) begin
                        ack_req_q <= 1'b1;
                        arb_q <= 1'b1;
                        event_q <= 1'b1;
                     end else begin
                        sto_q <= 1'b0;
                     end
                  end
               endcase
            end
            ST_BITS: begin
               if (scl_rise) begin
                  shreg_q <= {shreg_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (tx_q && !sda_oe_q && !sda_s) begin
                     arb_q <= 1'b1;
                     if (master_q) begin
                        master_q <= 1'b0;
                        tx_q <= 1'b0;
                     end
                  end
               end
               if (scl_fall) begin
                  if (bit_cnt_q == BITS_PER_BYTE) begin
                     sda_oe_q <= 1'b0;
                     if (!tx_q) begin
                        event_q <= 1'b1;
                        ack_req_q <= 1'b1;
                        state_q <= ST_HOLD;
                        rx_hold_q <= 1'b1;
                        scl_oe_q <= 1'b1;
                        if (first_q && !master_q) begin
                           sta_q <= 1'b1;
                        end
                     end else begin
                        state_q <= ST_ACK;
                     end
                  end else begin
                     sda_oe_q <= tx_q & ~shreg_q[7];
                  end
               end
            end
            ST_ACK: begin
               if (scl_rise && tx_q) begin
                  ack_q <= ~sda_s;
               end
               if (scl_fall) begin
                  scl_oe_q <= 1'b1;
                  sda_oe_q <= 1'b0;
                  first_q <= 1'b0;
                  if (tx_q) begin
                     event_q <= 1'b1;
                     state_q <= ST_HOLD;
                     rx_hold_q <= 1'b0;
                  end else if (nack_addr_q) begin
                     mute_nack_q <= 1'b1;
                     state_q <= ST_IDLE;
                  end else begin
                     state_q <= ST_NEXT;
                  end
               end
            end
            ST_HOLD: begin
               scl_oe_q <= 1'b1;
               if (rx_hold_q) begin
                  sda_oe_q <= ack_q;
               end
               if (go) begin
                  if (rx_hold_q) begin
                     state_q <= ST_ACK;
                     sda_oe_q <= ack_eff;
                     nack_addr_q <= first_q & ~master_q & ~ack_eff;
                     tim_q <= HALF_CYC;
                     scl_oe_q <= master_q;
                  end else begin
                     state_q <= ST_NEXT;
                  end
               end
            end
            ST_NEXT: begin
               written_q <= 1'b0;
               bit_cnt_q <= 4'h0;
               phase_q <= 2'h0;
               hi_q <= 1'b0;
               if (master_q && sto_q) begin
                  state_q <= ST_STOP;
                  sda_oe_q <= 1'b1;
                  tim_q <= QUARTER_CYC;
               end else if (master_q && sta_q) begin
                  state_q <= ST_RSTART;
                  sda_oe_q <= 1'b0;
                  tim_q <= QUARTER_CYC;
               end else begin
                  state_q <= ST_BITS;
                  tx_q <= written_q;
                  sda_oe_q <= written_q & ~shreg_q[7];
                  scl_oe_q <= master_q;
                  tim_q <= HALF_CYC;
               end
            end
         endcase
         // Conditions driven by other parties override the sequence
         if (start_det) begin
            busy_q <= 1'b1;
            mute_nack_q <= 1'b0;
            if (!master_q) begin
               scl_oe_q <= 1'b0;
               sda_oe_q <= 1'b0;
               state_q <= mute_s ? ST_IDLE : ST_BITS;
               tx_q <= 1'b0;
               first_q <= 1'b1;
               bit_cnt_q <= 4'h0;
               written_q <= 1'b0;
            end
         end
         if (stop_det) begin
            busy_q <= 1'b0;
            if (state_q != ST_STOP && state_q != ST_IDLE &&
                !(first_q && !master_q && state_q == ST_BITS)) begin
               state_q <= ST_IDLE;
               scl_oe_q <= 1'b0;
               sda_oe_q <= 1'b0;
               event_q <= 1'b1;
               sto_q <= 1'b1;
               ack_req_q <= 1'b0;
               if (master_q) begin
                  master_q <= 1'b0;
                  tx_q <= 1'b0;
                  arb_q <= 1'b1;
               end
            end
         end
      end
   end

   // Open-drain data values are always low
   always_ff @(posedge clk_link) begin
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
   end
   assign scl_o = scl_o_q;
   assign sda_o = sda_o_q;
   assign scl_oe = scl_oe_q;
   assign sda_oe = sda_oe_q;

   // Checks on the byte engine
   a_hold_scl_low: assert property (@(posedge clk_link) disable iff (eng_rst)
      (state_q == ST_HOLD) && event_q && !go && !stop_det && !start_det |=> scl_oe_q)
      else $error("SCL released during byte hold");
   a_arb_clear: assert property (@(posedge clk_link) disable iff (eng_rst)
      go |=> (!arb_q || event_q))
      else $error("Arbitration flag survived event clear");
   a_rx_event: assert property (@(posedge clk_link) disable iff (eng_rst)
      $rose(event_q) && ack_req_q && (state_q != ST_IDLE)
         |-> (state_q == ST_HOLD) && rx_hold_q && !sda_oe_q)
      else $error("Receive event not before acknowledge");
   a_tx_event: assert property (@(posedge clk_link) disable iff (eng_rst)
      (state_q == ST_ACK) && tx_q && scl_fall |=> event_q && !rx_hold_q)
      else $error("Transmit event not after acknowledge");
   a_shift_msb: assert property (@(posedge clk_link) disable iff (eng_rst)
      (state_q == ST_BITS) && scl_rise && !start_det |=>
         shreg_q[0] == $past(sda_s) && shreg_q[7:1] == $past(shreg_q[6:0]))
      else $error("Shift register did not sample the bus");
   a_start_req: assert property (@(posedge clk_link) disable iff (eng_rst)
      (state_q == ST_IDLE) && sta_q && !busy_q && !event_q && !start_det && !stop_det
         |=> (state_q == ST_START) && master_q && sda_oe_q ##1 !scl_oe_q)
      else $error("Begin request did not start master");
   a_ack_drive: assert property (@(posedge clk_link) disable iff (eng_rst)
      (state_q == ST_HOLD) && rx_hold_q && !go && !start_det && !stop_det
         |=> sda_oe_q == $past(ack_q))
      else $error("Acknowledge value not on SDA");
   a_nack_mute: assert property (@(posedge clk_link) disable iff (eng_rst)
      mute_nack_q && (state_q == ST_IDLE) && !start_det && !sta_q |=> state_q == ST_IDLE)
      else $error("Muted slave left idle without START");
   a_slave_stop: assert property (@(posedge clk_link) disable iff (eng_rst)
      stop_det && !master_q && (state_q == ST_HOLD || state_q == ST_ACK)
         |=> (state_q == ST_IDLE) && event_q && sto_q && !scl_oe_q)
      else $error("STOP did not end slave mode");
   a_cmd_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cmd_valid && cmd_ready_q |=> !cmd_ready_q [*2])
      else $error("Command accepted twice");

   c_master_start: cover property (@(posedge clk_link) disable iff (eng_rst)
      (state_q == ST_START) ##1 (state_q == ST_HOLD));
   c_slave_addr: cover property (@(posedge clk_link) disable iff (eng_rst)
      $rose(event_q) && !master_q && sta_q && ack_req_q);
   c_arb_lost: cover property (@(posedge clk_link) disable iff (eng_rst)
      $rose(arb_q) && !master_q);
   c_stop_event: cover property (@(posedge clk_link) disable iff (eng_rst)
      stop_det && !master_q ##1 event_q && sto_q);

endmodule

//--- include/twb_pkg.sv
// Contract
// - Buffer shifts out MSB first and samples the bus while shifting.
// - Lost arbitration turns master transmitter into slave receiver, buffer intact.
// - Always one of four modes; master from START until lost arbitration or STOP.
// - Byte event before acknowledge as receiver, after acknowledge as transmitter.
// - Master transmit: START, address byte with write bit, then data bytes.
// - No buffer write after master transmit event: master receive on flag clear.
// - Master receive: each received byte sets acknowledge request and raises event.
// - Outgoing acknowledge follows acknowledge control bit: 1 gives ACK, 0 NACK.
// - Buffer written as active master receiver switches to master transmit.
// - Unmuted: START plus address enters slave receive with event; STOP leaves it.
// - NACKed slave address mutes slave events until the next START.
// - Buffer written as active slave receiver switches to slave transmit.
// - Buffer write after a slave transmit NACK flags an error condition.
// - No buffer write after slave transmit event falls back to slave receive.
// - Status vector: controller role, transmit direction, begin and end requests.
// - Codes 1110 start sent, 1100 byte sent, 1000 byte received awaiting ack.
// - Code 0100 slave byte sent, error via lost flag; 0101 stop during slave send.
// - Code 0010 slave address received, or repeated START lost arbitration.
// - Code 0001 lost during STOP, STOP while addressed, or lost to a STOP.
// - Code 0000 slave byte awaiting ack, or lost while sending master data.
// - While the byte event flag is set, SCL is held low; the code releases it in idle after a STOP or a lost START/STOP.
// - Clearing the byte event flag also clears the arbitration lost flag.
// - Begin request starts master mode with START once the bus is free.
// - End request in master mode sends STOP after acknowledge, then START if requested.
package twb_pkg;

   // Bus timing, least times, rounded up to link clock cycles
   localparam int LINK_PERIOD_PS = 30000;
   localparam int HALF_BIT_NS = 5000;
   localparam int QUARTER_BIT_NS = 2500;
   localparam int HALF_CYC_INT = (HALF_BIT_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int QUARTER_CYC_INT = (QUARTER_BIT_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam logic [7:0] HALF_CYC = 8'(HALF_CYC_INT);
   localparam logic [7:0] QUARTER_CYC = 8'(QUARTER_CYC_INT);
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Engine states, Gray along the transmit byte path
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_START = 3'h1,
      ST_BITS = 3'h3,
      ST_ACK = 3'h2,
      ST_HOLD = 3'h6,
      ST_NEXT = 3'h7,
      ST_STOP = 3'h5,
      ST_RSTART = 3'h4
   } twb_state_t;

   // Software command
   typedef struct packed {
      logic clear_event;
      logic write_ctrl;
      logic begin_condition_request;
      logic end_condition_request;
      logic ack;
      logic write_data;
      logic [7:0] data;
   } twb_cmd_t;

   // Status seen by software
   typedef struct packed {
      logic [3:0] vector;
      logic ack_req;
      logic arb_lost;
      logic ack;
      logic event_flag;
      logic busy;
      logic [7:0] data;
   } twb_stat_t;

   localparam twb_stat_t STAT_RESET = '0;
   localparam twb_cmd_t CMD_RESET = '0;

endpackage

//--- dv/twb_slave_model.sv
`timescale 1ns/10ps
module twb_slave_model (
   input wire logic scl,
   input wire logic sda,
   output logic sda_pull,
   output logic [7:0] got
);
   int cnt = 0;
   initial sda_pull = 1'b0;
   // A START or STOP restarts the byte count and frees SDA
   always @(sda) begin
      if (scl === 1'b1) begin
         cnt = 0;
         sda_pull = 1'b0;
      end
   end
   // Bits enter MSB first on each rising SCL
   always @(posedge scl) begin
      if (cnt < 8) begin
         got = {got[6:0], sda};
         cnt = cnt + 1;
      end
   end
   // Acknowledge each byte, then release SDA after the ack clock
   always @(negedge scl) begin
      if (cnt == 8) begin
         sda_pull = 1'b1;
         cnt = 9;
      end else if (cnt == 9) begin
         sda_pull = 1'b0;
         cnt = 0;
      end
   end
endmodule

//--- dv/testbench.sv
`timescale 1ns/10ps
module testbench;
   import twb_pkg::*;
   logic clk_sys, clk_link, rst_n, enable, mute, cmd_valid, cmd_ready;
   logic scl_o, scl_oe, sda_o, sda_oe, pull;
   logic [7:0] got;
   twb_cmd_t cmd;
   twb_stat_t status;
   int err_total = 0;
   int checked = 0;
   // Wired-AND bus with pull-ups
   wire logic scl = !scl_oe;
   wire logic sda = !(sda_oe || pull);

   twb_engine dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link), .enable(enable),
      .peripheral_event_mute(mute), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
      .status(status), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe));
   twb_slave_model slave (.scl(scl), .sda(sda), .sda_pull(pull), .got(got));

   // Clocks, unrelated in phase
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = !clk_sys;
   end
   initial begin
      clk_link = 1'b0;
      #7;
      forever #15 clk_link = !clk_link;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Hands one command over and waits for the handshake to return
   task automatic send(input twb_cmd_t c);
      int n;
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd = c;
      n = 0;
      // Ready is looked at away from the edge; the command is taken at the next rise
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n = n + 1;
      end
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 200) begin
         @(negedge clk_sys);
         n = n + 1;
      end
      check("cmd_ready", {15'h0, cmd_ready}, 16'h1);
   endtask

   // Waits bounded for the status vector and the event flag to match together
   task automatic wait_status(input logic [3:0] vec, input logic evt);
      int n;
      n = 0;
      while ((status.vector !== vec || status.event_flag !== evt) && n < 40000) begin
         @(negedge clk_sys);
         n = n + 1;
      end
   endtask

   initial begin
      #380us;
      err_total = err_total + 1;
      tally_and_finish();
   end

   initial begin
      rst_n = 1'b0;
      enable = 1'b1;
      mute = 1'b0;
      cmd_valid = 1'b0;
      cmd = CMD_RESET;
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (100) @(negedge clk_sys);
      // Request a START as master
      send({1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00});
      wait_status(4'he, 1'b1);
      check("start vector", {12'h0, status.vector}, 16'h000e);
      repeat (60) @(negedge clk_sys);
      check("scl held", {14'h0, scl_oe, scl}, 16'h0002);
      // Address with write direction, written only while the event is set
      send({1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'ha4});
      wait_status(4'hc, 1'b1);
      check("sent vector", {12'h0, status.vector}, 16'h000c);
      check("ack seen", {15'h0, status.ack}, 16'h0001);
      check("ack request", {15'h0, status.ack_req}, 16'h0000);
      check("byte on wire", {8'h0, got}, 16'h00a4);
      check("buffer", {8'h0, status.data}, 16'h00a4);
      // Request STOP and leave master mode
      send({1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00});
      wait_status(4'h0, 1'b0);
      check("idle vector", {12'h0, status.vector}, 16'h0000);
      repeat (2000) @(negedge clk_sys);
      check("bus free", {14'h0, scl, sda}, 16'h0003);
      check("busy after stop", {15'h0, status.busy}, 16'h0000);
      // Second transfer: address with read direction, then one received byte
      send({1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00});
      wait_status(4'he, 1'b1);
      check("restart vector", {12'h0, status.vector}, 16'h000e);
      send({1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'ha5});
      wait_status(4'hc, 1'b1);
      check("read address", {8'h0, got}, 16'h00a5);
      check("no arb lost", {15'h0, status.arb_lost}, 16'h0000);
      // No buffer write before the clear: the engine turns receiver
      send({1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00});
      wait_status(4'h8, 1'b1);
      check("rx vector", {12'h0, status.vector}, 16'h0008);
      check("rx ack request", {15'h0, status.ack_req}, 16'h0001);
      check("rx byte", {8'h0, status.data}, 16'h00ff);
      // Last byte: NACK and STOP together
      send({1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00});
      wait_status(4'h0, 1'b0);
      check("rx idle vector", {12'h0, status.vector}, 16'h0000);
      repeat (2000) @(negedge clk_sys);
      check("bus free again", {14'h0, scl, sda}, 16'h0003);
      check("open drain", {14'h0, scl_o, sda_o}, 16'h0000);
      tally_and_finish();
   end
endmodule
